// File: hw/rscl_pkg.sv
// Constants used by the reset strap latch; its LED driver uses none of them
package rscl_pkg;
   // Register byte offsets on the Wishbone slave
   localparam logic [7:0] OFS_STRAP = 8'h00;
   localparam logic [7:0] OFS_FIXED = 8'h04;
   localparam logic [7:0] OFS_CTRL = 8'h08;
   // Strap status field positions
   localparam int STRAP_SEL_A = 0;
   localparam int STRAP_SEL_B = 1;
   localparam int STRAP_SEL_C = 2;
   localparam int STRAP_CODE_LO = 3;
   localparam int STRAP_CODE_HI = 4;
   localparam int STRAP_DONE = 5;
   localparam int STRAP_FIX_EN = 6;
   // Control field positions and reset value
   localparam int CTRL_SPEED_EN = 0;
   localparam int CTRL_SUSP_EN = 1;
   localparam logic [1:0] CTRL_RESET = 2'h3;
   // Fixed-port code values
   localparam logic [1:0] CODE_NONE = 2'h0;
   localparam logic [1:0] CODE_P1 = 2'h1;
   localparam logic [1:0] CODE_P12 = 2'h2;
   localparam logic [1:0] CODE_P123 = 2'h3;
   // Reset values of latched straps and read data
   localparam logic STRAP_RESET = 1'b0;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
   // Strap capture phases after reset release
   typedef enum logic [1:0] {ST_SEL, ST_FIX, ST_RUN} rscl_phase_e;
endpackage : rscl_pkg

// File: hw/rscl_led_pol.sv
// Indicator pin driver with latched polarity and tristate hold
`timescale 1ns/1ps
module rscl_led_pol (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Control
   input wire logic drive,
   input wire logic enable,
   input wire logic active,
   input wire logic active_low,
   // Pin
   output logic pin_out,
   output logic pin_oe_n
);
   logic out_r;
   logic oe_n_r;

   // Inactive level follows polarity, so a disabled LED stays dark
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         out_r <= 1'b0;
      end else begin
         out_r <= (enable & active) ^ active_low;
      end
   end

   // Pin stays released until the strap has been read
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         oe_n_r <= 1'b1;
      end else begin
         oe_n_r <= ~drive;
      end
   end

   assign pin_out = out_r;
   assign pin_oe_n = oe_n_r;
endmodule : rscl_led_pol

// File: hw/rscl_strap_latch.sv
// Reset strap latch, fixed-port decode, LED polarity and Wishbone regs
//
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
module rscl_strap_latch #(
   parameter bit PKG_HAS_FIXED_STRAP = 1'b1,
   parameter bit PKG_HAS_SEL_C = 1'b1,
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Serial clock pin, open drain
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_n,
   // Serial data pin, open drain
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // Upstream speed LED pin
   input wire logic upstream_speed_led_in,
   output logic upstream_speed_led_out,
   output logic upstream_speed_led_oe_n,
   // Suspend LED pin
   input wire logic suspend_led_in,
   output logic suspend_led_out,
   output logic suspend_led_oe_n,
   // Third select strap input
   input wire logic method_select_bit_c,
   // Serial port engine side
   input wire logic ser_scl_pull_low,
   input wire logic ser_sda_pull_low,
   output logic ser_scl_level,
   output logic ser_sda_level,
   // Hub state and configuration
   input wire logic hs_link,
   input wire logic hub_active,
   input wire logic fixed_strap_cfg_en,
   output logic [2:0] method_code,
   output logic [3:1] fixed_ports,
   output logic straps_valid
);
   // Decoder reads the low address byte, so the bus needs eight bits
   if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
      $error("rscl_strap_latch: ADDR_W must be 8 to 32");
   end

   function automatic logic [2:0] fixed_mask(input logic [1:0] code);
      case (code)
         rscl_pkg::CODE_NONE: fixed_mask = 3'h0;
         rscl_pkg::CODE_P1: fixed_mask = 3'h1;
         rscl_pkg::CODE_P12: fixed_mask = 3'h3;
         default: fixed_mask = 3'h7;
      endcase
   endfunction : fixed_mask

   rscl_pkg::rscl_phase_e phase_r;
   logic sel_a_r, sel_b_r, sel_c_r, fix_en_r;
   logic [1:0] fixed_port_code_r;
   logic [1:0] ctrl_r;
   logic [31:0] rdata_r;
   logic ack_r;
   logic scl_oe_n_r, sda_oe_n_r, scl_lvl_r, sda_lvl_r;
   logic [2:0] method_r;
   logic [3:1] fixed_ports_r;
   logic valid_r;
   logic run;
   logic req;

   assign run = (phase_r == rscl_pkg::ST_RUN);
   assign req = wb_cyc_i & wb_stb_i & ~ack_r;

   // Selects first, so the mapping outside can answer before fixed straps
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         phase_r <= rscl_pkg::ST_SEL;
      end else begin
         case (phase_r)
            rscl_pkg::ST_SEL: phase_r <= rscl_pkg::ST_FIX;
            rscl_pkg::ST_FIX: phase_r <= rscl_pkg::ST_RUN;
            rscl_pkg::ST_RUN: phase_r <= rscl_pkg::ST_RUN;
            default: phase_r <= rscl_pkg::ST_SEL;
         endcase
      end
   end

   // Select straps, caught at the first edge after release
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sel_a_r <= rscl_pkg::STRAP_RESET;
         sel_b_r <= rscl_pkg::STRAP_RESET;
         sel_c_r <= rscl_pkg::STRAP_RESET;
      end else if (phase_r == rscl_pkg::ST_SEL) begin
         sel_a_r <= scl_in;
         sel_b_r <= upstream_speed_led_in;
         sel_c_r <= PKG_HAS_SEL_C & method_select_bit_c;
      end
   end

   // Fixed-port straps, gated by package and configuration
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fixed_port_code_r <= rscl_pkg::CODE_NONE;
         fix_en_r <= rscl_pkg::STRAP_RESET;
      end else if (phase_r == rscl_pkg::ST_FIX) begin
         fix_en_r <= PKG_HAS_FIXED_STRAP & fixed_strap_cfg_en;
         if (PKG_HAS_FIXED_STRAP && fixed_strap_cfg_en) begin
            fixed_port_code_r <= {sda_in, suspend_led_in};
         end
      end
   end

   // Outputs registered from the latched straps, steady from straps_valid to the next reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         method_r <= 3'h0;
         fixed_ports_r <= 3'h0;
         valid_r <= 1'b0;
      end else begin
         method_r <= {sel_c_r, sel_b_r, sel_a_r};
         fixed_ports_r <= fixed_mask(fixed_port_code_r);
         valid_r <= run;
      end
   end

   // Serial port pins, released until the straps are read
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         scl_oe_n_r <= 1'b1;
         sda_oe_n_r <= 1'b1;
         scl_lvl_r <= 1'b1;
         sda_lvl_r <= 1'b1;
      end else begin
         scl_oe_n_r <= ~(run & ser_scl_pull_low);
         sda_oe_n_r <= ~(run & ser_sda_pull_low);
         scl_lvl_r <= scl_in;
         sda_lvl_r <= sda_in;
      end
   end

   // Control register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_r <= rscl_pkg::CTRL_RESET;
      end else if (req && wb_we_i && wb_sel_i[0] &&
                   wb_adr_i[7:0] == rscl_pkg::OFS_CTRL) begin
         ctrl_r <= wb_dat_i[1:0];
      end
   end

   // Answer every access one cycle later; unmapped reads return zero
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ack_r <= 1'b0;
         rdata_r <= rscl_pkg::RDATA_RESET;
      end else begin
         ack_r <= req;
         rdata_r <= rscl_pkg::RDATA_RESET;
         if (req && !wb_we_i) begin
            case (wb_adr_i[7:0])
               rscl_pkg::OFS_STRAP: begin
                  rdata_r[rscl_pkg::STRAP_SEL_A] <= sel_a_r;
                  rdata_r[rscl_pkg::STRAP_SEL_B] <= sel_b_r;
                  rdata_r[rscl_pkg::STRAP_SEL_C] <= sel_c_r;
                  rdata_r[rscl_pkg::STRAP_CODE_LO] <= fixed_port_code_r[0];
                  rdata_r[rscl_pkg::STRAP_CODE_HI] <= fixed_port_code_r[1];
                  rdata_r[rscl_pkg::STRAP_DONE] <= run;
                  rdata_r[rscl_pkg::STRAP_FIX_EN] <= fix_en_r;
               end
               rscl_pkg::OFS_FIXED: begin
                  rdata_r[3:1] <= fixed_mask(fixed_port_code_r);
               end
               rscl_pkg::OFS_CTRL: rdata_r[1:0] <= ctrl_r;
               default: rdata_r <= rscl_pkg::RDATA_RESET;
            endcase
         end
      end
   end

   // Speed LED: asserted at high speed, polarity from select b
   rscl_led_pol u_speed_led (
      .clk(clk),
      .resetn(resetn),
      .drive(run),
      .enable(ctrl_r[rscl_pkg::CTRL_SPEED_EN]),
      .active(hs_link),
      .active_low(sel_b_r),
      .pin_out(upstream_speed_led_out),
      .pin_oe_n(upstream_speed_led_oe_n)
   );

   // Suspend LED: polarity from low bit of the fixed-port code
   rscl_led_pol u_susp_led (
      .clk(clk),
      .resetn(resetn),
      .drive(run),
      .enable(ctrl_r[rscl_pkg::CTRL_SUSP_EN]),
      .active(hub_active),
      .active_low(fixed_port_code_r[0]),
      .pin_out(suspend_led_out),
      .pin_oe_n(suspend_led_oe_n)
   );

   assign wb_dat_o = rdata_r;
   assign wb_ack_o = ack_r;
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe_n = scl_oe_n_r;
   assign sda_oe_n = sda_oe_n_r;
   assign ser_scl_level = scl_lvl_r;
   assign ser_sda_level = sda_lvl_r;
   assign method_code = method_r;
   assign fixed_ports = fixed_ports_r;
   assign straps_valid = valid_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   chk_fixed_sample: assert property (
      phase_r == rscl_pkg::ST_FIX && fixed_strap_cfg_en && PKG_HAS_FIXED_STRAP
      |=> fixed_port_code_r == $past({sda_in, suspend_led_in}))
      else $error("fixed-port straps not sampled");
   chk_fixed_gate: assert property (
      !fix_en_r |-> fixed_port_code_r == rscl_pkg::CODE_NONE)
      else $error("fixed-port code set while strap disabled");
   chk_fixed_decode: assert property (
      run ##1 run |-> fixed_ports == fixed_mask(fixed_port_code_r))
      else $error("fixed-port mask does not match code");
   // Release edge itself still sees reset, so it starts no latch check
   chk_sel_a_latch: assert property (
      resetn && phase_r == rscl_pkg::ST_SEL |=> sel_a_r == $past(scl_in))
      else $error("select a not latched from clock pin");
   chk_sel_b_latch: assert property (
      resetn && phase_r == rscl_pkg::ST_SEL |=>
      sel_b_r == $past(upstream_speed_led_in))
      else $error("select b not latched from speed LED pin");
   chk_sel_c_latch: assert property (
      resetn && phase_r == rscl_pkg::ST_SEL |=>
      sel_c_r == (PKG_HAS_SEL_C & $past(method_select_bit_c)))
      else $error("select c not latched or not zero without its pin");
   chk_speed_pol: assert property (
      run |=> upstream_speed_led_out ==
      (($past(ctrl_r[0]) & $past(hs_link)) ^ sel_b_r))
      else $error("speed LED level or polarity wrong");
   chk_speed_drive: assert property (
      run && ctrl_r[0] && hs_link ##1 run |->
      upstream_speed_led_out != sel_b_r && !upstream_speed_led_oe_n)
      else $error("speed LED not asserted at high speed");
   chk_serial_pass: assert property (
      run |=> sda_oe_n == !$past(ser_sda_pull_low) &&
      scl_oe_n == !$past(ser_scl_pull_low))
      else $error("serial pins not following the serial port");
   chk_susp_pol: assert property (
      run && !ctrl_r[1] |=> suspend_led_out == fixed_port_code_r[0])
      else $error("suspend LED idle level wrong for code");
   chk_strap_hold: assert property (
      run |=> $stable(method_code) && $stable(fixed_port_code_r) &&
      method_code == {sel_c_r, sel_b_r, sel_a_r})
      else $error("latched straps changed after release");
   chk_wb_answer: assert property (
      req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus access not acked for exactly one cycle");

   cov_release: cover property (phase_r == rscl_pkg::ST_SEL ##2 run);
   cov_all_fixed: cover property (run && fixed_port_code_r == 2'h3);
   cov_bus_read: cover property (req && !wb_we_i ##1 wb_ack_o);
   cov_hs_led: cover property (run && hs_link && sel_b_r);
endmodule : rscl_strap_latch

// File: testbench/rscl_board.sv
// Board strap resistors around the strap latch pins, resolving each pin level
`timescale 1ns/1ps
module rscl_board (
   // Strap resistor levels {sda, scl, speed, susp}
   input wire logic [3:0] strap,
   // Device pin drivers
   input wire logic [3:0] pin_out,
   input wire logic [3:0] pin_oe_n,
   // Resolved pin levels
   output logic [3:0] pin_lvl
);
   // Released pin settles to its strap resistor
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pin_lvl[i] = pin_oe_n[i] ? strap[i] : pin_out[i];
      end
   end
endmodule : rscl_board

// File: testbench/testbench.sv
// Self-checking bench for the reset strap latch
`timescale 1ns/1ps
module testbench;
   typedef struct packed {
      logic [4:0] st;
      logic [2:0] mc;
      logic [3:1] fp;
   } rscl_row_s;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
   logic wb_ack_o, sel_c = 1'b0, pl_scl = 1'b0, pl_sda = 1'b0;
   logic hs_link = 1'b0, hub_active = 1'b0, cfg_en = 1'b1;
   logic [3:0] strap = 4'h0;
   wire [3:0] p_out, p_oe_n, lvl;
   logic [2:0] method_code;
   logic [3:1] fixed_ports;
   logic straps_valid, scl_lvl, sda_lvl;
   int n_fail = 0, cmp_count = 0, cyc = 0;
   rscl_row_s rows[8] = '{
      '{5'h00, 3'h0, 3'h0}, '{5'h05, 3'h1, 3'h1},
      '{5'h0A, 3'h2, 3'h3}, '{5'h0F, 3'h3, 3'h7},
      '{5'h13, 3'h4, 3'h7}, '{5'h16, 3'h5, 3'h3},
      '{5'h19, 3'h6, 3'h1}, '{5'h1C, 3'h7, 3'h0}};

   always #50 clk = ~clk;

   rscl_board u_board (.strap(strap), .pin_out(p_out),
      .pin_oe_n(p_oe_n), .pin_lvl(lvl));

   rscl_strap_latch u_dut (.clk(clk), .resetn(resetn),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .scl_in(lvl[2]), .scl_out(p_out[2]), .scl_oe_n(p_oe_n[2]),
      .sda_in(lvl[3]), .sda_out(p_out[3]), .sda_oe_n(p_oe_n[3]),
      .upstream_speed_led_in(lvl[1]),
      .upstream_speed_led_out(p_out[1]),
      .upstream_speed_led_oe_n(p_oe_n[1]),
      .suspend_led_in(lvl[0]), .suspend_led_out(p_out[0]),
      .suspend_led_oe_n(p_oe_n[0]), .method_select_bit_c(sel_c),
      .ser_scl_pull_low(pl_scl), .ser_sda_pull_low(pl_sda),
      .ser_scl_level(scl_lvl), .ser_sda_level(sda_lvl),
      .hs_link(hs_link), .hub_active(hub_active),
      .fixed_strap_cfg_en(cfg_en), .method_code(method_code),
      .fixed_ports(fixed_ports), .straps_valid(straps_valid));

   task automatic stop_test();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string nm, input logic [31:0] exp,
                      input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
      end
   endtask : chk

   // Straps {c,b,a,hi,lo} stay on the pins through reset release
   task automatic do_reset(input logic [4:0] st);
      resetn <= 1'b0;
      sel_c <= st[4];
      strap <= {st[1], st[2], st[3], st[0]};
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      repeat (6) @(posedge clk);
   endtask : do_reset

   task automatic wb_xfer(input logic we, input logic [7:0] adr,
                          input logic [31:0] wd, output logic [31:0] r);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      wb_sel_i <= 4'hF;
      @(posedge clk);
      while (wb_ack_o !== 1'b1 && n < 50) begin
         n++;
         @(posedge clk);
      end
      if (n == 50) n_fail++;
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk);
   endtask : wb_xfer

   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         stop_test();
      end
   end

   initial begin
      @(posedge clk);
      foreach (rows[i]) begin
         do_reset(rows[i].st);
         chk("sel_a", 32'(rows[i].mc[0]), 32'(method_code[0]));
         chk("sel_b", 32'(rows[i].mc[1]), 32'(method_code[1]));
         chk("sel_c", 32'(rows[i].mc[2]), 32'(method_code[2]));
         chk("method", 32'(rows[i].mc), 32'(method_code));
         chk("fixed", 32'(rows[i].fp), 32'(fixed_ports));
         chk("valid", 32'h0000_0001, {31'h0, straps_valid});
         for (int h = 0; h < 2; h++) begin
            hs_link <= h[0];
            hub_active <= h[0];
            repeat (2) @(posedge clk);
            chk("spd", 32'(h[0] ^ rows[i].st[3]), 32'(p_out[1]));
            chk("spd_oe", 32'h0, {31'h0, p_oe_n[1]});
            chk("susp", 32'(h[0] ^ rows[i].st[0]), 32'(p_out[0]));
         end
      end
      // Strap pins moving after release must not reach the latches
      strap <= 4'hF;
      sel_c <= 1'b0;
      repeat (3) @(posedge clk);
      chk("hold_mc", 32'h0000_0007, {29'h0, method_code});
      chk("hold_fp", 32'h0, {29'h0, fixed_ports});
      pl_scl <= 1'b1;
      pl_sda <= 1'b1;
      repeat (3) @(posedge clk);
      chk("scl_oe", 32'h0, {31'h0, p_oe_n[2]});
      chk("sda_oe", 32'h0, {31'h0, p_oe_n[3]});
      chk("sda_lvl", 32'h0, {30'h0, scl_lvl, sda_lvl});
      // Reset while the serial pins are pulled must release every pin
      resetn <= 1'b0;
      @(posedge clk);
      chk("rst_oe", 32'h0000_000F, 32'(p_oe_n));
      chk("rst_out", 32'h0,
          {24'h0, method_code, fixed_ports, straps_valid, wb_ack_o});
      pl_scl <= 1'b0;
      pl_sda <= 1'b0;
      cfg_en <= 1'b0;
      do_reset(5'h03);
      chk("fix_off", 32'h0, {29'h0, fixed_ports});
      wb_xfer(1'b0, 8'h00, 32'h0, rd);
      chk("strap_reg", 32'h0000_0020, rd);
      wb_xfer(1'b0, 8'h08, 32'h0, rd);
      chk("ctrl_rst", 32'h0000_0003, rd);
      wb_xfer(1'b1, 8'h08, 32'h0, rd);
      wb_xfer(1'b0, 8'h08, 32'h0, rd);
      chk("ctrl_wr", 32'h0, rd);
      wb_xfer(1'b0, 8'h0C, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
      hub_active <= 1'b1;
      repeat (2) @(posedge clk);
      chk("susp_off", 32'h0, {31'h0, p_out[0]});
      stop_test();
   end
endmodule : testbench
